// [dtvi_core_model.sv]
// Behavioural processor core that answers the block's interrupt request
`timescale 1ns/100ps
module dtvi_core_model (
    input wire logic clk_i, // Core clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire logic irq_i, // Level request from the block
    input wire logic [3:0] wait_i, // Cycles to stall before answering
    output logic int_cycle_o // One-cycle interrupt machine cycle
);
    logic [3:0] cnt_reg; // Cycles waited so far
    logic armed_reg; // Low after a machine cycle until the request drops
    // One machine cycle per request, after a prompt or slow wait
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 4'h0;
            armed_reg <= 1'b1;
            int_cycle_o <= 1'b0;
        end else begin
            int_cycle_o <= 1'b0;
            if (!irq_i) begin
                cnt_reg <= 4'h0;
                armed_reg <= 1'b1;
            end else if (armed_reg && cnt_reg >= wait_i) begin
                int_cycle_o <= 1'b1;
                armed_reg <= 1'b0;
            end else if (armed_reg) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule

// [dtvi_pkg.sv]
// Package for the dual timer and vectored interrupt block
package dtvi_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_TMR = 8'hF1;
    localparam logic [7:0] ADDR_CNT1 = 8'hF2;
    localparam logic [7:0] ADDR_SECOND_PRESCALER = 8'hF3;
    localparam logic [7:0] ADDR_CNT0 = 8'hF4;
    localparam logic [7:0] ADDR_FIRST_PRESCALER = 8'hF5;
    localparam logic [7:0] ADDR_IPR = 8'hF9;
    localparam logic [7:0] ADDR_IRQ = 8'hFA;
    localparam logic [7:0] ADDR_IMR = 8'hFB;
    localparam logic [7:0] ADDR_CMP = 8'hE0;
    // Timer mode register field positions
    localparam int TMR_LOAD0 = 0;
    localparam int TMR_RUN0 = 1;
    localparam int TMR_LOAD1 = 2;
    localparam int TMR_RUN1 = 3;
    localparam int TMR_INMODE_LO = 4;
    localparam int TMR_INMODE_HI = 5;
    localparam int TMR_EXTCLK = 6;
    // Prescaler field positions
    localparam int PRE_AUTO = 0;
    localparam int PRE_INT = 1;
    localparam int PRE_DIV_LO = 2;
    localparam int PRE_DIV_HI = 7;
    // Mask register global enable bit
    localparam int IMR_GLOBAL = 7;
    // Reset values
    localparam logic [7:0] TMR_RESET = 8'h00;
    localparam logic [7:0] PRE_RESET = 8'h00;
    localparam logic [7:0] IMR_RESET = 8'h00;
    localparam logic [7:0] IPR_RESET = 8'h00;
    localparam logic [5:0] IRQ_RESET = 6'h00;
    // Internal clock divides by four for both timers
    localparam logic [1:0] INT_DIV_LAST = 2'h3;
    // Number of interrupt sources
    localparam int NUM_IRQ = 6;
    // External timer input modes
    typedef enum logic [1:0] {
        DTVI_IN_CLOCK = 2'h0,
        DTVI_IN_GATE = 2'h1,
        DTVI_IN_TRIG_NR = 2'h2,
        DTVI_IN_TRIG_R = 2'h3
    } dtvi_inmode_type;
    // Register bus request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dtvi_bus_type;
    // Grant answer carrier
    typedef struct packed {
        logic valid;
        logic [2:0] source;
        logic [7:0] vector_addr;
    } dtvi_grant_type;
endpackage

// [dtvi_top.sv]
// Dual 8-bit timers with prescalers and a six source vectored interrupt unit
`timescale 1ns/100ps
// Notes on behaviour
// - Two 8-bit counters, each with 6-bit prescaler
// - Second prescaler internal or external; first internal
// - Prescalers divide by 1 through 64
// - Counters decrement per pulse from 1..256
// - Both at end raise timer request
// - Start, stop, continue, or reload counter
// - Single-pass halts; auto reload continues
// - Counters readable unchanged; prescalers not readable
// - Second clock: internal/4 or port input
// - Pin is clock, trigger, or gate
// - Six requests: three falls, rise, timers
// - Mask enables globally and per request
// - Programmable priority picks among pending requests
// - Grant disables interrupts; core saves state
// - Vector byte pair at twice source index
// - Comparator outputs feed edge requests when enabled
// - Timers and edges active while halted
module dtvi_top
    import dtvi_pkg::*;
(
    input wire logic clk_i, // 40 MHz clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire dtvi_pkg::dtvi_bus_type bus_i, // Register bus request
    output logic [7:0] rdata_o, // Read data, one cycle after read
    input wire logic port_input_one_i, // Pin, also timer input
    input wire logic port_input_two_i, // Pin
    input wire logic port_input_three_i, // Pin, reference
    input wire logic cmp_a_i, // First comparator output
    input wire logic cmp_b_i, // Second comparator output
    input wire logic int_cycle_i, // Core runs an interrupt machine cycle
    output dtvi_pkg::dtvi_grant_type grant_o, // Granted source and vector
    output logic irq_o, // Level interrupt request
    output logic wake_o // Enabled request pending, resumes halted core
);
    import dtvi_pkg::*;

    // Reset release synchroniser
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers: five inputs, two stages, then one history stage
    logic [4:0] pin_raw;
    logic [4:0] sync1_reg; // First stage, read only by second
    logic [4:0] sync2_reg; // Second stage
    logic [4:0] hist_reg; // Previous synchronised value
    assign pin_raw = {cmp_b_i, cmp_a_i, port_input_three_i, port_input_two_i, port_input_one_i};
    // Pins idle high: resetting to the idle level keeps a false edge out after reset
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
            hist_reg <= 5'h1F;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            hist_reg <= sync2_reg;
        end
    end

    // Registers
    logic [7:0] tmr_reg; // Timer mode register
    logic [7:0] pre_reg [2]; // Prescaler setups, write only
    logic [7:0] init_reg [2]; // Initial counter values
    logic [7:0] ipr_reg; // Interrupt priority register
    logic [7:0] imr_reg; // Interrupt mask register
    logic cmp_en_reg; // Comparator enable
    logic [5:0] irq_reg; // Pending flags
    logic [5:0] irq_next;
    logic [7:0] cnt_reg [2]; // Counter values
    logic [5:0] pscnt_reg [2]; // Prescaler counts
    logic [1:0] div4_reg; // Internal divide-by-four
    logic trig_run_reg; // Trigger has started second timer
    logic [1:0] eoc; // End of count events
    logic [1:0] load_req; // Reload from initial value

    // Edge sources, optionally from comparators
    logic p1_fall, p2_fall, p2_rise, p3_fall, tin_level, tin_rise;
    always_comb begin
        if (cmp_en_reg) begin
            p1_fall = hist_reg[3] & ~sync2_reg[3];
            p2_fall = hist_reg[4] & ~sync2_reg[4];
            p2_rise = ~hist_reg[4] & sync2_reg[4];
            tin_level = sync2_reg[3];
            tin_rise = ~hist_reg[3] & sync2_reg[3];
        end else begin
            p1_fall = hist_reg[0] & ~sync2_reg[0];
            p2_fall = hist_reg[1] & ~sync2_reg[1];
            p2_rise = ~hist_reg[1] & sync2_reg[1];
            tin_level = sync2_reg[0];
            tin_rise = ~hist_reg[0] & sync2_reg[0];
        end
        p3_fall = hist_reg[2] & ~sync2_reg[2];
    end

    // Register writes
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= TMR_RESET;
            pre_reg[0] <= PRE_RESET;
            pre_reg[1] <= PRE_RESET;
            init_reg[0] <= 8'h00;
            init_reg[1] <= 8'h00;
            ipr_reg <= IPR_RESET;
            cmp_en_reg <= 1'b0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_TMR: tmr_reg <= bus_i.wdata;
                ADDR_FIRST_PRESCALER: pre_reg[0] <= bus_i.wdata;
                ADDR_SECOND_PRESCALER: pre_reg[1] <= bus_i.wdata;
                ADDR_CNT0: init_reg[0] <= bus_i.wdata;
                ADDR_CNT1: init_reg[1] <= bus_i.wdata;
                ADDR_IPR: ipr_reg <= bus_i.wdata;
                ADDR_CMP: cmp_en_reg <= bus_i.wdata[0];
                default: ;
            endcase
        end
    end

    // Load request bits are not self-clearing; a set bit keeps reloading until software clears it
    assign load_req = {tmr_reg[TMR_LOAD1], tmr_reg[TMR_LOAD0]};

    // Second timer clock source and input mode
    dtvi_inmode_type in_mode;
    logic int_tick, ext_sel, tick1_src, run1_gate;
    assign in_mode = dtvi_inmode_type'(tmr_reg[TMR_INMODE_HI:TMR_INMODE_LO]);
    assign int_tick = (div4_reg == INT_DIV_LAST);
    assign ext_sel = tmr_reg[TMR_EXTCLK] && (in_mode == DTVI_IN_CLOCK);
    always_comb begin
        tick1_src = ext_sel ? tin_rise : int_tick;
        run1_gate = 1'b1;
        case (in_mode)
            DTVI_IN_GATE: run1_gate = tin_level;
            DTVI_IN_TRIG_NR, DTVI_IN_TRIG_R: run1_gate = trig_run_reg;
            default: run1_gate = 1'b1;
        endcase
    end

    // Divide-by-four for the internal count clock; runs while core halts
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div4_reg <= 2'h0;
        end else begin
            div4_reg <= div4_reg + 2'h1;
        end
    end

    // Trigger state: retriggerable restarts, nonretriggerable only while not running
    logic trig_fire;
    assign trig_fire = tin_rise && ((in_mode == DTVI_IN_TRIG_R) ||
                       (in_mode == DTVI_IN_TRIG_NR && !trig_run_reg));
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_run_reg <= 1'b0;
        end else if (trig_fire) begin
            trig_run_reg <= 1'b1;
        end else if (eoc[1]) begin
            trig_run_reg <= 1'b0;
        end
    end

    // Timer channels: prescaler then counter
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tim
            logic run, tick, ps_end;
            logic halt_reg; // Single pass has stopped at zero
            assign run = tmr_reg[g ? TMR_RUN1 : TMR_RUN0] && (g ? run1_gate : 1'b1);
            assign tick = g ? tick1_src : int_tick;
            assign ps_end = (pscnt_reg[g] == 6'h00);
            assign eoc[g] = run && tick && ps_end && (cnt_reg[g] == 8'h01);
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pscnt_reg[g] <= 6'h00;
                    cnt_reg[g] <= 8'h00;
                    halt_reg <= 1'b1;
                end else if (load_req[g] || (g == 1 && trig_fire)) begin
                    pscnt_reg[g] <= pre_reg[g][PRE_DIV_HI:PRE_DIV_LO] - 6'h01;
                    cnt_reg[g] <= init_reg[g];
                    halt_reg <= 1'b0;
                end else if (run && tick && !halt_reg) begin
                    if (ps_end) begin
                        pscnt_reg[g] <= pre_reg[g][PRE_DIV_HI:PRE_DIV_LO] - 6'h01;
                        if (cnt_reg[g] == 8'h01) begin
                            // Auto reload keeps counting, single pass halts at zero
                            cnt_reg[g] <= pre_reg[g][PRE_AUTO] ? init_reg[g] : 8'h00;
                            halt_reg <= !pre_reg[g][PRE_AUTO];
                        end else begin
                            // Zero wraps to all ones, so a loaded zero counts 256
                            cnt_reg[g] <= cnt_reg[g] - 8'h01;
                        end
                    end else begin
                        pscnt_reg[g] <= pscnt_reg[g] - 6'h01;
                    end
                end
            end
        end
    endgenerate

    // Prescaler source bit is kept for software; the ticks are chosen above
    logic [1:0] unused_pre_int;
    assign unused_pre_int = {pre_reg[1][PRE_INT], pre_reg[0][PRE_INT]};

    // Priority resolution: rotate by priority register, lowest index wins
    logic [5:0] active;
    logic [2:0] rot;
    logic [2:0] win;
    logic any_win;
    assign active = irq_reg & imr_reg[5:0] & {6{imr_reg[IMR_GLOBAL]}};
    assign rot = (ipr_reg[2:0] > 3'h5) ? 3'h0 : ipr_reg[2:0];
    always_comb begin
        win = 3'h0;
        any_win = 1'b0;
        for (int i = 5; i >= 0; i--) begin
            if (active[(i + rot) % NUM_IRQ]) begin
                win = 3'((i + rot) % NUM_IRQ);
                any_win = 1'b1;
            end
        end
    end

    // Grant when the core runs an interrupt machine cycle
    logic grant_now;
    assign grant_now = int_cycle_i && any_win;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            grant_o <= '0;
        end else begin
            grant_o.valid <= grant_now;
            grant_o.source <= grant_now ? win : grant_o.source;
            grant_o.vector_addr <= grant_now ? {4'h0, win, 1'b0} : grant_o.vector_addr;
        end
    end

    // Interrupt mask: software writes; grant clears the global enable
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            imr_reg <= IMR_RESET;
        end else begin
            // Software write lands; a grant in the same cycle still closes the global enable
            if (bus_i.wr && bus_i.addr == ADDR_IMR) begin
                imr_reg <= bus_i.wdata;
            end
            if (grant_now) begin
                imr_reg[IMR_GLOBAL] <= 1'b0;
            end
        end
    end

    // Pending flags: sources set, software or grant clears, set wins
    logic [5:0] set_vec;
    assign set_vec = {eoc[1], eoc[0], p2_rise, p1_fall, p3_fall, p2_fall};
    always_comb begin
        irq_next = irq_reg;
        if (bus_i.wr && bus_i.addr == ADDR_IRQ) begin
            irq_next = bus_i.wdata[5:0];
        end else if (bus_i.rd && bus_i.addr == ADDR_IRQ) begin
            // Reading the flags clears them; an event in the same cycle survives
            irq_next = 6'h00;
        end
        if (grant_now) begin
            irq_next[win] = 1'b0;
        end
        irq_next = irq_next | set_vec;
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= IRQ_RESET;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Interrupt outputs
    assign irq_o = |active;
    assign wake_o = |active;

    // Read data: counters read live, prescalers read zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_TMR: rdata_o <= {tmr_reg[7:4], tmr_reg[3], 1'b0, tmr_reg[1], 1'b0};
                ADDR_CNT0: rdata_o <= cnt_reg[0];
                ADDR_CNT1: rdata_o <= cnt_reg[1];
                ADDR_IPR: rdata_o <= ipr_reg;
                ADDR_IRQ: rdata_o <= {2'h0, irq_reg};
                ADDR_IMR: rdata_o <= imr_reg;
                ADDR_CMP: rdata_o <= {7'h00, cmp_en_reg};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Assertions
    property p_grant_clears;
        @(posedge clk_i) disable iff (!rst_n)
        grant_now |=> !imr_reg[IMR_GLOBAL];
    endproperty
    a_grant_clears: assert property (p_grant_clears) else $error("grant left interrupts on");
    property p_vector;
        @(posedge clk_i) disable iff (!rst_n)
        grant_now |=> grant_o.valid && grant_o.vector_addr == {4'h0, $past(win), 1'b0};
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");
    property p_eoc_flag;
        @(posedge clk_i) disable iff (!rst_n)
        eoc[0] |=> irq_reg[4];
    endproperty
    a_eoc_flag: assert property (p_eoc_flag) else $error("timer flag missing");
    property p_mask;
        @(posedge clk_i) disable iff (!rst_n)
        !imr_reg[IMR_GLOBAL] |-> !irq_o;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request raised");
    property p_read_cnt;
        @(posedge clk_i) disable iff (!rst_n)
        bus_i.rd && bus_i.addr == ADDR_CNT0 |=> rdata_o == $past(cnt_reg[0]);
    endproperty
    a_read_cnt: assert property (p_read_cnt) else $error("counter read wrong");
    property p_pre_hidden;
        @(posedge clk_i) disable iff (!rst_n)
        bus_i.rd && bus_i.addr == ADDR_FIRST_PRESCALER |=> rdata_o == 8'h00;
    endproperty
    a_pre_hidden: assert property (p_pre_hidden) else $error("prescaler readable");
    property p_single;
        @(posedge clk_i) disable iff (!rst_n)
        eoc[0] && !pre_reg[0][PRE_AUTO] && !load_req[0] |=> cnt_reg[0] == 8'h00;
    endproperty
    a_single: assert property (p_single) else $error("single pass did not halt");
    property p_fall;
        @(posedge clk_i) disable iff (!rst_n)
        p3_fall |=> irq_reg[1];
    endproperty
    a_fall: assert property (p_fall) else $error("edge flag missing");
    c_grant: cover property (@(posedge clk_i) disable iff (!rst_n) grant_now);
    c_eoc1: cover property (@(posedge clk_i) disable iff (!rst_n) eoc[1]);
    c_rise: cover property (@(posedge clk_i) disable iff (!rst_n) p2_rise);
endmodule

// [dual_timer_and_vectored_interrupts_bench.sv]
// Self-checking bench for the dual timer and vectored interrupt block
`timescale 1ns/100ps
module dual_timer_and_vectored_interrupts_bench;
    import dtvi_pkg::*;
    logic clk_i;
    logic arst_n_i;
    dtvi_bus_type bus_i;
    logic [7:0] rdata_o;
    logic p1;
    logic p2;
    logic p3;
    logic cmp_a;
    logic cmp_b;
    logic int_cycle;
    logic irq;
    logic wake;
    dtvi_grant_type grant;
    logic [3:0] core_wait; // Core stall before a machine cycle
    int err_total;
    int n_compared;

    dtvi_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .port_input_one_i(p1), .port_input_two_i(p2), .port_input_three_i(p3),
        .cmp_a_i(cmp_a), .cmp_b_i(cmp_b), .int_cycle_i(int_cycle), .grant_o(grant),
        .irq_o(irq), .wake_o(wake));
    dtvi_core_model core (.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_i(irq),
        .wait_i(core_wait), .int_cycle_o(int_cycle));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Verdict and end of run
    task automatic report_and_stop();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask

    // One-cycle read, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        d = rdata_o;
    endtask

    // Byte comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read and compare
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        reg_rd(a, v);
        chk(v, exp);
    endtask

    // Wait for a grant pulse and judge source, vector and the global disable
    task automatic wait_grant(input logic [2:0] src);
        int i;
        for (i = 0; i < 60 && grant.valid !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({7'h0, grant.valid}, 8'h01);
        chk({5'h0, grant.source}, {5'h0, src});
        chk(grant.vector_addr, {4'h0, src, 1'b0});
        chk({7'h0, irq}, 8'h00);
    endtask

    // Load flags, open the mask and expect one vectored grant
    task automatic grant_case(input logic [7:0] flags, input logic [7:0] interrupt_priority_order, input logic [2:0] src);
        reg_wr(ADDR_IPR, interrupt_priority_order);
        reg_wr(ADDR_IRQ, flags);
        reg_wr(ADDR_IMR, 8'hBF);
        wait_grant(src);
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Reset values, read-write access and an unmapped place
    task automatic t_regs();
        chk_rd(ADDR_TMR, 8'h00);
        chk_rd(ADDR_IMR, 8'h00);
        chk_rd(ADDR_IRQ, 8'h00);
        reg_wr(8'h10, 8'h5A);
        chk_rd(8'h10, 8'h00);
        reg_wr(ADDR_IPR, 8'h05);
        chk_rd(ADDR_IPR, 8'h05);
    endtask

    // Single pass down to zero, read without disturbing, end-of-count flag
    task automatic t_single();
        logic [7:0] v;
        reg_wr(ADDR_FIRST_PRESCALER, 8'h06);
        reg_wr(ADDR_CNT0, 8'h03);
        reg_wr(ADDR_TMR, 8'h03);
        reg_wr(ADDR_TMR, 8'h02);
        repeat (80) @(posedge clk_i);
        chk_rd(ADDR_CNT0, 8'h00);
        chk_rd(ADDR_CNT0, 8'h00);
        reg_rd(ADDR_IRQ, v);
        chk(v & 8'h10, 8'h10);
        reg_wr(ADDR_TMR, 8'h00);
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Divide by 64, stop, continue, then reload the initial value with the counter left stopped
    task automatic t_stop_go();
        logic [7:0] v1;
        logic [7:0] v2;
        reg_wr(ADDR_FIRST_PRESCALER, 8'h02);
        reg_wr(ADDR_CNT0, 8'h80);
        reg_wr(ADDR_TMR, 8'h03);
        reg_wr(ADDR_TMR, 8'h02);
        repeat (700) @(posedge clk_i);
        reg_wr(ADDR_TMR, 8'h00);
        reg_rd(ADDR_CNT0, v1);
        chk(v1, 8'h7E);
        repeat (600) @(posedge clk_i);
        chk_rd(ADDR_CNT0, v1);
        reg_wr(ADDR_TMR, 8'h02);
        repeat (600) @(posedge clk_i);
        reg_rd(ADDR_CNT0, v2);
        chk({7'h0, v2 < v1 && v2 + 8'h04 > v1}, 8'h01);
        reg_wr(ADDR_TMR, 8'h01);
        reg_wr(ADDR_TMR, 8'h00);
        chk_rd(ADDR_CNT0, 8'h80);
    endtask

    // Auto reload keeps raising the second timer's flag
    task automatic t_reload();
        logic [7:0] v;
        reg_wr(ADDR_SECOND_PRESCALER, 8'h07);
        reg_wr(ADDR_CNT1, 8'h02);
        reg_wr(ADDR_TMR, 8'h0C);
        reg_wr(ADDR_TMR, 8'h08);
        repeat (40) @(posedge clk_i);
        reg_wr(ADDR_IRQ, 8'h00);
        repeat (40) @(posedge clk_i);
        reg_rd(ADDR_IRQ, v);
        chk(v & 8'h20, 8'h20);
        reg_wr(ADDR_TMR, 8'h00);
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Pin edges, level request, slow core grant, then masked polling
    task automatic t_edges();
        core_wait <= 4'hF;
        reg_wr(ADDR_IMR, 8'h81);
        p2 <= 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        chk({6'h0, irq, wake}, 8'h03);
        wait_grant(3'h0);
        chk_rd(ADDR_IMR, 8'h01);
        p2 <= 1'b1;
        p3 <= 1'b0;
        p1 <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk_rd(ADDR_IRQ, 8'h0E);
        chk({7'h0, irq}, 8'h00);
        chk_rd(ADDR_IRQ, 8'h00);
        p3 <= 1'b1;
        p1 <= 1'b1;
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Comparator outputs replace the first two pins as edge sources
    task automatic t_compare();
        reg_wr(ADDR_CMP, 8'h01);
        repeat (4) @(posedge clk_i);
        reg_wr(ADDR_IRQ, 8'h00);
        cmp_b <= 1'b0;
        cmp_a <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk_rd(ADDR_IRQ, 8'h05);
        reg_wr(ADDR_IRQ, 8'h00);
        cmp_b <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk_rd(ADDR_IRQ, 8'h08);
        reg_wr(ADDR_CMP, 8'h00);
        cmp_a <= 1'b1;
        repeat (8) @(posedge clk_i);
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Pin as external clock for the second timer, then as a gate
    task automatic t_ext();
        logic [7:0] v;
        reg_wr(ADDR_SECOND_PRESCALER, 8'h05);
        reg_wr(ADDR_CNT1, 8'h05);
        reg_wr(ADDR_TMR, 8'h4C);
        reg_wr(ADDR_TMR, 8'h48);
        chk_rd(ADDR_TMR, 8'h48);
        repeat (3) begin
            p1 <= 1'b0;
            repeat (4) @(posedge clk_i);
            p1 <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        chk_rd(ADDR_CNT1, 8'h02);
        p1 <= 1'b0;
        reg_wr(ADDR_TMR, 8'h18);
        repeat (40) @(posedge clk_i);
        chk_rd(ADDR_CNT1, 8'h02);
        reg_wr(ADDR_IRQ, 8'h00);
        p1 <= 1'b1;
        repeat (40) @(posedge clk_i);
        reg_rd(ADDR_IRQ, v);
        chk(v & 8'h20, 8'h20);
        reg_wr(ADDR_TMR, 8'h00);
        reg_wr(ADDR_IRQ, 8'h00);
    endtask

    // Hang guard
    initial begin
        #1000000;
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        err_total = 0;
        n_compared = 0;
        bus_i = '0;
        {p1, p2, p3, cmp_a, cmp_b} = 5'h1F;
        core_wait = 4'h0;
        arst_n_i = 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_single();
        t_stop_go();
        t_reload();
        t_edges();
        t_compare();
        t_ext();
        for (int s = 0; s < 6; s++) begin
            core_wait <= 4'(s * 3);
            grant_case(8'h01 << s, 8'h00, 3'(s));
        end
        grant_case(8'h0A, 8'h00, 3'h1);
        grant_case(8'h0A, 8'h03, 3'h3);
        report_and_stop();
    end
endmodule
